//--- cbq_pkg.sv
// Function
// - Qualifier register is 16 bits, software read/write, all fields reset to zero.
// - Bits 15:10 reserved, read as zero; software writes zero there.
// - Bit 9 picks peripheral bus or X/Y memory bus, only when cycle-select picks peripheral.
// - Bit 8 picks X bus (0) or Y bus (1) when X/Y selection is active.
// - Bits 7:6: 00 off, 01 peripheral, 10 internal CPU bus, 11 peripheral.
// - Bits 5:4: 00 off, 01 fetch, 10 data, 11 either.
// - Bits 3:2: 00 off, 01 read, 10 write, 11 either.
// - Bits 1:0: 00 any size, 01 byte, 10 word, 11 longword.
// - X bus: its low 16 bits compare with break data upper half.
// - Y bus: its low 16 bits compare with break data lower half.
`default_nettype none
package cbq_pkg;
    localparam logic [31:0] QUAL_OFFSET      = 32'h0000_0000;
    localparam logic [31:0] DATA_OFFSET      = 32'h0000_0004;
    localparam logic [31:0] MASK_OFFSET      = 32'h0000_0008;
    localparam logic [31:0] STATUS_OFFSET    = 32'h0000_000C;
    localparam logic [15:0] QUAL_RESET       = 16'h0000;
    localparam logic [15:0] QUAL_WRITE_MASK  = 16'h03FF;
    localparam logic [31:0] DATA_RESET       = 32'h0000_0000;
    localparam int          MEM_SEL_BIT      = 9;
    localparam int          XY_CHOICE_BIT    = 8;
    localparam int          CYCLE_SEL_LSB    = 6;
    localparam int          ACCESS_SEL_LSB   = 4;
    localparam int          DIR_SEL_LSB      = 2;
    localparam int          SIZE_SEL_LSB     = 0;
    localparam logic [1:0]  SEL_OFF          = 2'h0;
    localparam logic [1:0]  CYC_PERIPH       = 2'h1;
    localparam logic [1:0]  CYC_INTERNAL     = 2'h2;
    localparam logic [1:0]  SIZE_BYTE        = 2'h1;
    localparam logic [1:0]  SIZE_WORD        = 2'h2;
    localparam logic [1:0]  SIZE_LONG        = 2'h3;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [2:0]  HSIZE_WORD32     = 3'h2;
    typedef enum logic [1:0] {
        BUS_NONE,
        BUS_INTERNAL,
        BUS_PERIPH,
        BUS_XY
    } watched_bus_t;
endpackage : cbq_pkg
`default_nettype wire

//--- cbq_field_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cbq_field_decode (
    input  wire logic [1:0] sel_in,
    input  wire logic       first_in,
    input  wire logic       second_in,
    output logic            enabled_out,
    output logic            pass_out
);
    // Common decode for the access-type and direction fields: 01 first, 10 second, 11 either.
    assign enabled_out = (sel_in != cbq_pkg::SEL_OFF);
    assign pass_out    = (sel_in[0] & first_in) | (sel_in[1] & second_in);
endmodule : cbq_field_decode
`default_nettype wire

//--- break_chan_b_cycle_qualifier.sv
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module break_chan_b_cycle_qualifier (
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        cycle_valid_in,
    input  wire logic        internal_cycle_in,
    input  wire logic        periph_cycle_in,
    input  wire logic        x_cycle_in,
    input  wire logic        y_cycle_in,
    input  wire logic        fetch_in,
    input  wire logic        write_in,
    input  wire logic [1:0]  size_in,
    input  wire logic [31:0] internal_cpu_data_bus_in,
    input  wire logic [31:0] peripheral_side_data_bus_in,
    input  wire logic [15:0] x_memory_data_bus_in,
    input  wire logic [15:0] y_memory_data_bus_in,
    output logic             cycle_match_out,
    output logic             data_match_out,
    output logic [1:0]       watched_bus_out
);
    logic [15:0]          channel_b_cycle_qualifier_r;
    logic [31:0]          channel_b_break_data_r;
    logic [31:0]          break_data_mask_r;
    logic                 wr_pend_r;
    logic [31:0]          wr_addr_r;
    logic [31:0]          hrdata_r;
    logic                 cycle_match_r;
    logic                 data_match_r;
    logic                 addr_phase;
    cbq_pkg::watched_bus_t bus_sel;
    logic                 bus_hit;
    logic                 acc_en;
    logic                 acc_ok;
    logic                 dir_en;
    logic                 dir_ok;
    logic                 size_ok;
    logic                 all_ok;
    logic [31:0]          cmp_bus;
    logic [31:0]          cmp_care;
    logic [1:0]           cyc_sel;
    logic [1:0]           size_sel;
    logic                 wr_qual;
    logic                 wr_data;
    logic                 wr_mask;
    logic [31:0]          rd_word;
    logic [31:0]          bit_differs;
    logic                 data_ok;

    assign addr_phase    = hsel_in & hready_in & (htrans_in == cbq_pkg::HTRANS_NONSEQ);
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_r;

    // Writes land at the data phase; reads are answered with zero wait states.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_phase & hwrite_in;
            wr_addr_r <= haddr_in;
        end
    end

    // Only exact word offsets decode, so a write to a hole in the map changes nothing.
    assign wr_qual = wr_pend_r && (wr_addr_r == cbq_pkg::QUAL_OFFSET);
    assign wr_data = wr_pend_r && (wr_addr_r == cbq_pkg::DATA_OFFSET);
    assign wr_mask = wr_pend_r && (wr_addr_r == cbq_pkg::MASK_OFFSET);

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            channel_b_cycle_qualifier_r <= cbq_pkg::QUAL_RESET;
        end else if (wr_qual) begin
            // Reserved bits are dropped so a stray one never reaches the decode.
            channel_b_cycle_qualifier_r <= hwdata_in[15:0] & cbq_pkg::QUAL_WRITE_MASK;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            channel_b_break_data_r <= cbq_pkg::DATA_RESET;
        end else if (wr_data) begin
            channel_b_break_data_r <= hwdata_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            break_data_mask_r <= cbq_pkg::DATA_RESET;
        end else if (wr_mask) begin
            break_data_mask_r <= hwdata_in;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr_in)
            cbq_pkg::QUAL_OFFSET:   rd_word = {16'h0000, channel_b_cycle_qualifier_r};
            cbq_pkg::DATA_OFFSET:   rd_word = channel_b_break_data_r;
            cbq_pkg::MASK_OFFSET:   rd_word = break_data_mask_r;
            cbq_pkg::STATUS_OFFSET: rd_word = {28'h000_0000, watched_bus_out,
                                               data_match_r, cycle_match_r};
            default:                rd_word = 32'h0000_0000;
        endcase
    end

    // Read data is captured at the address phase and then stands through the data phase.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hrdata_r <= 32'h0000_0000;
        end else if (addr_phase && !hwrite_in) begin
            hrdata_r <= rd_word;
        end
    end

    assign cyc_sel  = channel_b_cycle_qualifier_r[cbq_pkg::CYCLE_SEL_LSB +: 2];
    assign size_sel = channel_b_cycle_qualifier_r[cbq_pkg::SIZE_SEL_LSB +: 2];

    always_comb begin
        bus_sel = cbq_pkg::BUS_NONE;
        if (cyc_sel == cbq_pkg::CYC_INTERNAL) begin
            bus_sel = cbq_pkg::BUS_INTERNAL;
        end else if (cyc_sel != cbq_pkg::SEL_OFF) begin
            // Memory-bus select only counts on the peripheral choice.
            bus_sel = channel_b_cycle_qualifier_r[cbq_pkg::MEM_SEL_BIT] ? cbq_pkg::BUS_XY
                                                                         : cbq_pkg::BUS_PERIPH;
        end
    end

    always_comb begin
        bus_hit  = 1'b0;
        cmp_bus  = 32'h0000_0000;
        cmp_care = 32'h0000_0000;
        unique case (bus_sel)
            cbq_pkg::BUS_NONE: begin
            end
            cbq_pkg::BUS_INTERNAL: begin
                bus_hit  = internal_cycle_in;
                cmp_bus  = internal_cpu_data_bus_in;
                cmp_care = 32'hFFFF_FFFF;
            end
            cbq_pkg::BUS_PERIPH: begin
                bus_hit  = periph_cycle_in;
                cmp_bus  = peripheral_side_data_bus_in;
                cmp_care = 32'hFFFF_FFFF;
            end
            cbq_pkg::BUS_XY: begin
                if (channel_b_cycle_qualifier_r[cbq_pkg::XY_CHOICE_BIT]) begin
                    bus_hit  = y_cycle_in;
                    cmp_bus  = {16'h0000, y_memory_data_bus_in};
                    cmp_care = 32'h0000_FFFF;
                end else begin
                    bus_hit  = x_cycle_in;
                    cmp_bus  = {x_memory_data_bus_in, 16'h0000};
                    cmp_care = 32'hFFFF_0000;
                end
            end
        endcase
    end

    cbq_field_decode access_decode (
        .sel_in      (channel_b_cycle_qualifier_r[cbq_pkg::ACCESS_SEL_LSB +: 2]),
        .first_in    (fetch_in),
        .second_in   (~fetch_in),
        .enabled_out (acc_en),
        .pass_out    (acc_ok)
    );

    cbq_field_decode direction_decode (
        .sel_in      (channel_b_cycle_qualifier_r[cbq_pkg::DIR_SEL_LSB +: 2]),
        .first_in    (~write_in),
        .second_in   (write_in),
        .enabled_out (dir_en),
        .pass_out    (dir_ok)
    );

    assign size_ok = (size_sel == cbq_pkg::SEL_OFF) || (size_sel == size_in);

    // An off field in access or direction disables the whole comparison.
    assign all_ok = cycle_valid_in & bus_hit & acc_en & acc_ok & dir_en & dir_ok & size_ok;

    // A bit counts only where the chosen bus carries it and the mask lets it through.
    generate
        for (genvar lane = 0; lane < 32; lane = lane + 1) begin : g_lane
            assign bit_differs[lane] = (cmp_bus[lane] ^ channel_b_break_data_r[lane])
                                       & cmp_care[lane] & ~break_data_mask_r[lane];
        end
    endgenerate
    assign data_ok = (bit_differs == 32'h0000_0000);

    // Both matches are registered so the break logic downstream sees one clean cycle.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cycle_match_r <= 1'b0;
        end else begin
            cycle_match_r <= all_ok;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            data_match_r <= 1'b0;
        end else begin
            data_match_r <= all_ok && data_ok;
        end
    end

    assign cycle_match_out = cycle_match_r;
    assign data_match_out  = data_match_r;
    assign watched_bus_out = bus_sel;
endmodule : break_chan_b_cycle_qualifier
`default_nettype wire

//--- cbq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cbq_asserts (
    input wire logic        core_clk_in,
    input wire logic        rst_b_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        cycle_valid_in,
    input wire logic        cycle_match_out,
    input wire logic [1:0]  watched_bus_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence qual_acc(logic w);
        hsel_in && hready_in && htrans_in == cbq_pkg::HTRANS_NONSEQ &&
        haddr_in == cbq_pkg::QUAL_OFFSET && hwrite_in == w;
    endsequence
    sequence qual_wr(logic [3:0] v);
        qual_acc(1'b1) ##1 hwdata_in[9:6] == v;
    endsequence
    a_rd_rsvd_zero: assert property (qual_acc(1'b0) |=> hrdata_out[31:10] == 22'h0)
        else $error("reserved bits read nonzero");
    a_wr_internal: assert property (qual_wr(4'h2) |=> watched_bus_out == 2'h1)
        else $error("internal bus not selected");
    a_wr_xy_bus: assert property (qual_wr(4'h9) |=> watched_bus_out == 2'h3)
        else $error("memory bus not selected");
    a_xy_ignored: assert property (qual_wr(4'hA) |=> watched_bus_out == 2'h1)
        else $error("memory bus choice not ignored");
    a_match_valid: assert property (cycle_match_out |-> $past(cycle_valid_in))
        else $error("match without bus cycle");
    a_off_nomatch: assert property (watched_bus_out == 2'h0 |=> !cycle_match_out)
        else $error("match with comparison off");
    a_bus_okay: assert property (hreadyout_out && !hresp_out)
        else $error("bus response not ready okay");
    a_reset_clear: assert property ($rose(rst_b_in) |-> watched_bus_out == 2'h0 && !cycle_match_out)
        else $error("state not cleared by reset");
endmodule : cbq_asserts
bind break_chan_b_cycle_qualifier cbq_asserts u_chk (
    .core_clk_in     (core_clk_in),
    .rst_b_in        (rst_b_in),
    .hsel_in         (hsel_in),
    .haddr_in        (haddr_in),
    .htrans_in       (htrans_in),
    .hwrite_in       (hwrite_in),
    .hwdata_in       (hwdata_in),
    .hready_in       (hready_in),
    .hrdata_out      (hrdata_out),
    .hreadyout_out   (hreadyout_out),
    .hresp_out       (hresp_out),
    .cycle_valid_in  (cycle_valid_in),
    .cycle_match_out (cycle_match_out),
    .watched_bus_out (watched_bus_out)
);
`default_nettype wire

//--- core_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
    input  wire logic   clk_in,
    output logic        valid_out,
    output logic [3:0]  bus_out,
    output logic [3:0]  kind_out,
    output logic [31:0] data_out
);
    initial begin
        valid_out = 1'b0;
        bus_out = 4'h0;
        kind_out = 4'h3;
        data_out = 32'h0000_0000;
    end
    // Data lines flip after each cycle so a stale value can never match by luck.
    task automatic run_cycle(input logic [3:0] bus, kind, input logic [31:0] d);
        @(posedge clk_in);
        valid_out <= 1'b1;
        bus_out <= bus;
        kind_out <= kind;
        data_out <= d;
        @(posedge clk_in);
        valid_out <= 1'b0;
        bus_out <= 4'h0;
        data_out <= ~d;
    endtask : run_cycle
endmodule : core_bus_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
    logic        core_clk_in;
    logic        rst_b_in;
    logic        hsel_in;
    logic [31:0] haddr_in;
    logic [1:0]  htrans_in;
    logic        hwrite_in;
    logic [31:0] hwdata_in;
    logic [31:0] hrdata_out;
    logic        hreadyout_out;
    logic        cycle_valid_in;
    logic        cycle_match_out;
    logic        data_match_out;
    logic [3:0]  bus;
    logic [3:0]  kind;
    logic [31:0] data;
    int          num_errors = 0;
    int          num_checks = 0;
    logic [31:0] tbl [20] = '{32'h0000_8B00, 32'h00BC_8B01, 32'h00BC_4500, 32'h007C_4501,
        32'h00FC_4201, 32'h027C_2201, 32'h027C_1200, 32'h037C_1601, 32'h037C_4600,
        32'h0298_8F01, 32'h0298_8700, 32'h00A4_8301, 32'h00A4_8700, 32'h00B0_8300,
        32'h008C_8300, 32'h00BD_8101, 32'h00BD_8200, 32'h00BE_8201, 32'h00BF_8301, 32'h00BF_8100};
    break_chan_b_cycle_qualifier DUT (
        .core_clk_in                 (core_clk_in),
        .rst_b_in                    (rst_b_in),
        .hsel_in                     (hsel_in),
        .haddr_in                    (haddr_in),
        .htrans_in                   (htrans_in),
        .hwrite_in                   (hwrite_in),
        .hsize_in                    (cbq_pkg::HSIZE_WORD32),
        .hwdata_in                   (hwdata_in),
        .hready_in                   (hreadyout_out),
        .hrdata_out                  (hrdata_out),
        .hreadyout_out               (hreadyout_out),
        .hresp_out                   (),
        .cycle_valid_in              (cycle_valid_in),
        .internal_cycle_in           (bus[3]),
        .periph_cycle_in             (bus[2]),
        .x_cycle_in                  (bus[1]),
        .y_cycle_in                  (bus[0]),
        .fetch_in                    (kind[3]),
        .write_in                    (kind[2]),
        .size_in                     (kind[1:0]),
        .internal_cpu_data_bus_in    (data),
        .peripheral_side_data_bus_in (data),
        .x_memory_data_bus_in        (data[15:0]),
        .y_memory_data_bus_in        (data[15:0]),
        .cycle_match_out             (cycle_match_out),
        .data_match_out              (data_match_out),
        .watched_bus_out             ()
    );
    core_bus_model core (.clk_in(core_clk_in), .valid_out(cycle_valid_in), .bus_out(bus),
        .kind_out(kind), .data_out(data));
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    task automatic report_and_stop;
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (hreadyout_out !== 1'b1 && n < 64);
        if (hreadyout_out !== 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    endtask : wait_rdy
    task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge core_clk_in);
        hsel_in <= 1'b1;
        htrans_in <= cbq_pkg::HTRANS_NONSEQ;
        haddr_in <= a;
        hwrite_in <= w;
        wait_rdy();
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_rdy();
        r = hrdata_out;
    endtask : ahb
    task automatic s_regs;
        logic [31:0] r;
        ahb(1'b0, cbq_pkg::QUAL_OFFSET, 32'h0000_0000, r);
        `CHK(r, 32'h0000_0000)
        ahb(1'b1, cbq_pkg::QUAL_OFFSET, 32'h0000_03FF, r);
        ahb(1'b0, cbq_pkg::QUAL_OFFSET, 32'h0000_0000, r);
        `CHK(r, 32'h0000_03FF)
        ahb(1'b1, 32'h0000_0040, 32'h1234_5678, r);
        ahb(1'b0, 32'h0000_0040, 32'h0000_0000, r);
        `CHK(r, 32'h0000_0000)
    endtask : s_regs
    task automatic s_cycles;
        logic [31:0] r;
        foreach (tbl[i]) begin
            ahb(1'b1, cbq_pkg::QUAL_OFFSET, {16'h0000, tbl[i][31:16]}, r);
            core.run_cycle(tbl[i][15:12], tbl[i][11:8], 32'h0000_0000);
            #1;
            `CHK(cycle_match_out, tbl[i][0])
        end
    endtask : s_cycles
    task automatic s_data;
        logic [31:0] r;
        ahb(1'b1, cbq_pkg::DATA_OFFSET, 32'hABCD_1234, r);
        ahb(1'b1, cbq_pkg::QUAL_OFFSET, 32'h0000_027E, r);
        core.run_cycle(4'h2, 4'h2, 32'h5A5A_ABCD);
        #1;
        `CHK(data_match_out, 1'b1)
        core.run_cycle(4'h2, 4'h2, 32'hABCD_1234);
        #1;
        `CHK(data_match_out, 1'b0)
        ahb(1'b1, cbq_pkg::QUAL_OFFSET, 32'h0000_037E, r);
        core.run_cycle(4'h1, 4'h2, 32'h5A5A_1234);
        #1;
        `CHK(data_match_out, 1'b1)
        ahb(1'b1, cbq_pkg::MASK_OFFSET, 32'h0000_00FF, r);
        core.run_cycle(4'h1, 4'h2, 32'h0000_12EE);
        #1;
        `CHK(data_match_out, 1'b1)
        ahb(1'b0, cbq_pkg::STATUS_OFFSET, 32'h0000_0000, r);
        `CHK(r, 32'h0000_000C)
    endtask : s_data
    initial begin
        rst_b_in = 1'b0;
        hsel_in = 1'b0;
        haddr_in = 32'h0000_0000;
        htrans_in = 2'h0;
        hwrite_in = 1'b0;
        hwdata_in = 32'h0000_0000;
        repeat (16) @(posedge core_clk_in);
        rst_b_in <= 1'b1;
        s_regs();
        s_cycles();
        s_data();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
